/* rtl/frg_ramp_core.sv */
// two-segment frequency ramp sequencer with its AXI4-Lite configuration registers
//
// Behaviour
// RL1: segment A's low 16 step bits live in their own register and join the upper bits into one step.
// RL2: segment B's step is a two's-complement value of 14 upper and 16 lower bits added once per ramp clock while B runs.
// RL3: each segment has a 16-bit length in phase-detector cycles used when the timeout counter ends it.
// RL4: segment B's double-clock bit makes its ramp clock two phase-detector cycles instead of one.
// RL5: segment B's accumulator-clear bit reloads the numerator at B's start, in automatic mode only.
// RL6: after segment A the next segment is A when its successor bit is 0, else B.
// RL7: segment A's advance source picks timeout, trigger A or trigger B, with code 3 never advancing.
// RL8: after segment B the next segment is A when its successor bit is 0, else B again.
// RL9: segment B's advance source picks timeout, trigger A or trigger B, with code 3 never advancing.
// RL10: the mode bit picks automatic ramping at 0 and pin-driven manual ramping at 1.
// RL11: with per-segment calibration set in automatic mode a VCO calibration starts at each segment.
// RL12: the calibration wait comes from the 10-bit wait count and the 3-bit shift.
// RL13: software writes zero to every reserved field.
// RL14: the register after the calibration-shift register is read-only and reads zero.
// RL15: trigger sources decode as off, clock-pin rise, direction-pin rise, always, clock fall, direction fall.
// RL16: segment A's upper 14 step bits sit in the preceding register and its double-clock bit acts like B's.
// RL17: each segment's two step registers form one 30-bit value, sign-extended into the numerator.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module frg_ramp_core
   import frg_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                clkEn,
   input  wire logic                sweepClockPin,
   input  wire logic                sweepDirectionPin,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output var  logic [31:0]         fracNumerator,
   output var  logic                segBActive,
   output var  logic                rampRunning,
   output var  logic                vcoCalStart,
   output var  logic                vcoCalBusy
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [15:0]       cfgReg [NUM_CFG_REGS];
   logic              rampEnable;
   logic [31:0]       numBase;

   logic [ADDR_W-1:0] awAddrHeld;
   logic [31:0]       wDataHeld;
   logic [3:0]        wStrbHeld;
   logic              awHave;
   logic              wHave;
   logic [7:0]        wrIdx;
   logic              wrFire;
   logic              wrMapped;
   logic [7:0]        rdIdx;

   assign wrIdx  = awAddrHeld[ADDR_W-1:2];
   assign wrFire = awHave && wHave && !s_axi_bvalid;
   assign rdIdx  = s_axi_araddr[ADDR_W-1:2];
   assign wrMapped = (wrIdx >= TRIG_CFG_IDX && wrIdx <= CAL_SHIFT_IDX) ||
                     wrIdx == UNUSED_RB_IDX || wrIdx == RAMP_CTRL_IDX ||
                     wrIdx == RAMP_STATUS_IDX || wrIdx == NUM_BASE_IDX;

   // ----------------------------------------------------------------
   // write channels: address and data taken in either order
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         awHave        <= 1'b0;
         wHave         <= 1'b0;
         awAddrHeld    <= '0;
         wDataHeld     <= 32'h0000_0000;
         wStrbHeld     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clkEn) begin
         s_axi_awready <= !awHave && !s_axi_awready;
         s_axi_wready  <= !wHave && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave        <= 1'b1;
            awAddrHeld    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave        <= 1'b1;
            wDataHeld    <= s_axi_wdata;
            wStrbHeld    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHave        <= 1'b0;
            wHave         <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers, one word each, low two lanes hold data except the numerator base, which uses all four
   // ----------------------------------------------------------------
   // reserved bits are stored as written; software is expected to keep them zero
   for (genvar i = 0; i < NUM_CFG_REGS; i++) begin : g_cfg
      localparam logic [7:0]  IDX = TRIG_CFG_IDX + 8'(i);
      localparam logic [15:0] RST = (IDX == CAL_WAIT_IDX)  ? CAL_WAIT_RESET :
                                    (IDX == CAL_SHIFT_IDX) ? CAL_SHIFT_RESET : CFG_RESET;
      always_ff @(posedge mclk) begin
         if (reset) begin
            cfgReg[i] <= RST;
         end else if (clkEn && wrFire && wrIdx == IDX) begin // RL1 RL16 RL13
            if (wStrbHeld[0]) begin
               cfgReg[i][7:0] <= wDataHeld[7:0];
            end
            if (wStrbHeld[1]) begin
               cfgReg[i][15:8] <= wDataHeld[15:8];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rampEnable <= 1'b0;
         numBase    <= NUM_BASE_RESET;
      end else if (clkEn && wrFire) begin
         if (wrIdx == RAMP_CTRL_IDX && wStrbHeld[0]) begin
            rampEnable <= wDataHeld[0];
         end
         if (wrIdx == NUM_BASE_IDX) begin
            for (int b = 0; b < 4; b++) begin
               if (wStrbHeld[b]) begin
                  numBase[8*b +: 8] <= wDataHeld[8*b +: 8];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   logic [STEP_W-1:0] segAStep;
   logic [STEP_W-1:0] segBStep;
   logic [3:0]        trigASrc;
   logic [3:0]        trigBSrc;
   logic [1:0]        segAAdv;
   logic [1:0]        segBAdv;
   logic [9:0]        calWaitCount;
   logic [2:0]        calShift;
   logic              manualMode;
   logic              segCalEn;
   logic              segASucc;
   logic              segBSucc;
   logic              segADbl;
   logic              segBDbl;
   logic              segAClr;
   logic              segBClr;
   logic [15:0]       segALen;
   logic [15:0]       segBLen;

   assign segAStep     = {cfgReg[1][15:STEP_HI_A_LSB], cfgReg[2]}; // RL1 RL16 RL17
   assign segBStep     = {cfgReg[5][13:0], cfgReg[6]}; // RL2 RL17
   assign trigASrc     = cfgReg[0][TRIG_A_LSB +: 4];
   assign trigBSrc     = cfgReg[0][TRIG_B_LSB +: 4];
   assign segAClr      = cfgReg[0][SEG_A_CLR_BIT];
   assign segADbl      = cfgReg[1][SEG_A_DBL_BIT];
   assign segALen      = cfgReg[3]; // RL3
   assign segAAdv      = cfgReg[4][1:0];
   assign segASucc     = cfgReg[4][SUCCESSOR_BIT];
   assign segBClr      = cfgReg[4][SEG_B_CLR_BIT];
   assign segBDbl      = cfgReg[4][SEG_B_DBL_BIT];
   assign segBLen      = cfgReg[7]; // RL3
   assign calWaitCount = cfgReg[8][CAL_WAIT_LSB +: 10];
   assign manualMode   = cfgReg[8][MANUAL_BIT]; // RL10
   assign segBSucc     = cfgReg[8][SUCCESSOR_BIT];
   assign segBAdv      = cfgReg[8][1:0];
   assign segCalEn     = cfgReg[9][SEG_CAL_BIT];
   assign calShift     = cfgReg[9][2:0];

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clkEn) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            if (rdIdx >= TRIG_CFG_IDX && rdIdx <= CAL_SHIFT_IDX) begin
               s_axi_rdata <= {16'h0000, cfgReg[4'(rdIdx - TRIG_CFG_IDX)]};
            end else if (rdIdx == UNUSED_RB_IDX) begin
               s_axi_rdata <= 32'h0000_0000; // RL14
            end else if (rdIdx == RAMP_CTRL_IDX) begin
               s_axi_rdata <= {31'h0000_0000, rampEnable};
            end else if (rdIdx == RAMP_STATUS_IDX) begin
               s_axi_rdata <= {29'h0000_0000, vcoCalBusy, segBActive, rampRunning};
            end else if (rdIdx == NUM_BASE_IDX) begin
               s_axi_rdata <= numBase;
            end else begin
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // sweep pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [2:0] clkPinSync;
   logic [2:0] dirPinSync;

   always_ff @(posedge mclk) begin
      if (reset) begin
         clkPinSync <= 3'h0;
         dirPinSync <= 3'h0;
      end else if (clkEn) begin
         clkPinSync <= {clkPinSync[1:0], sweepClockPin};
         dirPinSync <= {dirPinSync[1:0], sweepDirectionPin};
      end
   end

   // stage 0 feeds only stage 1; edges compare stages 1 and 2
   function automatic logic trig_hit(input logic [3:0] src, input logic [2:0] ck,
                                     input logic [2:0] dr);
      unique case (src)
         TRIG_CLK_RISE: trig_hit = ck[1] && !ck[2];
         TRIG_DIR_RISE: trig_hit = dr[1] && !dr[2];
         TRIG_ALWAYS:   trig_hit = 1'b1;
         TRIG_CLK_FALL: trig_hit = !ck[1] && ck[2];
         TRIG_DIR_FALL: trig_hit = !dr[1] && dr[2];
         default:       trig_hit = 1'b0;
      endcase
   endfunction : trig_hit

   logic trigA;
   logic trigB;
   assign trigA = trig_hit(trigASrc, clkPinSync, dirPinSync); // RL15
   assign trigB = trig_hit(trigBSrc, clkPinSync, dirPinSync); // RL15

   // ----------------------------------------------------------------
   // segment sequencer
   // ----------------------------------------------------------------
   frg_state_t     state;
   logic           curIsB;
   logic           halfTick;
   logic [15:0]    lenCnt;
   logic [CAL_CNT_W-1:0] calCnt;
   logic [CAL_CNT_W-1:0] calTarget;
   logic [1:0]     curAdv;
   logic [15:0]    curLen;
   logic           curDbl;
   logic           advance;
   logic           nextIsB;
   logic           rampTick;
   logic           startCal;
   logic           startClr;

   assign calTarget = CAL_CNT_W'({calWaitCount, 7'h00} >> (3'h7 - calShift)); // RL12
   assign curAdv    = curIsB ? segBAdv : segAAdv;
   assign curLen    = curIsB ? segBLen : segALen;
   assign curDbl    = curIsB ? segBDbl : segADbl;
   assign rampTick  = !curDbl || halfTick; // RL4 RL16
   assign nextIsB   = curIsB ? segBSucc : segASucc; // RL6 RL8
   assign startCal  = segCalEn && !manualMode; // RL11

   always_comb begin
      unique case (curAdv) // RL7 RL9
         ADV_TIMEOUT: advance = {1'b0, curLen} <= {1'b0, lenCnt} + 17'h00001; // RL3
         ADV_TRIG_A:  advance = trigA;
         ADV_TRIG_B:  advance = trigB;
         default:     advance = 1'b0;
      endcase
   end

   assign startClr = !manualMode && (nextIsB ? segBClr : segAClr); // RL5

   always_ff @(posedge mclk) begin
      if (reset) begin
         state       <= FRG_IDLE;
         curIsB      <= 1'b0;
         halfTick    <= 1'b0;
         lenCnt      <= 16'h0000;
         calCnt      <= '0;
         vcoCalStart <= 1'b0;
      end else if (clkEn) begin
         vcoCalStart <= 1'b0;
         unique case (state)
            FRG_IDLE: begin
               curIsB   <= 1'b0;
               lenCnt   <= 16'h0000;
               halfTick <= 1'b0;
               if (rampEnable) begin
                  state       <= startCal ? FRG_CAL : FRG_RUN;
                  vcoCalStart <= startCal;
                  calCnt      <= '0;
               end
            end
            FRG_CAL: begin
               calCnt <= calCnt + 1'b1;
               if (!rampEnable) begin
                  state  <= FRG_IDLE;
                  curIsB <= 1'b0;
               end else if (calCnt + 1'b1 >= calTarget) begin // RL12
                  state <= FRG_RUN;
               end
            end
            FRG_RUN: begin
               halfTick <= !halfTick;
               lenCnt   <= lenCnt + 16'h0001;
               if (!rampEnable) begin
                  // drop segment B with the stop so status never shows B while idle
                  state  <= FRG_IDLE;
                  curIsB <= 1'b0;
               end else if (advance) begin
                  curIsB      <= nextIsB; // RL6 RL8
                  lenCnt      <= 16'h0000;
                  halfTick    <= 1'b0;
                  calCnt      <= '0;
                  vcoCalStart <= startCal; // RL11
                  state       <= startCal ? FRG_CAL : FRG_RUN;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // numerator accumulator
   // ----------------------------------------------------------------
   logic [STEP_W-1:0] curStep;
   logic              stepNow;

   assign curStep = curIsB ? segBStep : segAStep;
   // manual mode steps only on trigger A, so the pin paces the ramp
   assign stepNow = manualMode ? trigA : rampTick; // RL10

   always_ff @(posedge mclk) begin
      if (reset) begin
         fracNumerator <= NUM_BASE_RESET;
      end else if (clkEn) begin
         if (state == FRG_IDLE) begin
            fracNumerator <= numBase;
         end else if (state == FRG_RUN && advance && startClr) begin
            fracNumerator <= numBase; // RL5
         end else if (state == FRG_RUN && stepNow) begin
            fracNumerator <= fracNumerator + {{2{curStep[STEP_W-1]}}, curStep}; // RL2 RL17
         end
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         segBActive  <= 1'b0;
         rampRunning <= 1'b0;
         vcoCalBusy  <= 1'b0;
      end else if (clkEn) begin
         segBActive  <= curIsB;
         rampRunning <= state != FRG_IDLE;
         vcoCalBusy  <= state == FRG_CAL;
      end
   end
endmodule : frg_ramp_core
`default_nettype wire

/* rtl/frg_pkg.sv */
// package: register map, field layout, reset values and encodings for the frequency ramp block
package frg_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [7:0] TRIG_CFG_IDX      = 8'h61;
   localparam logic [7:0] SEG_A_STEP_HI_IDX = 8'h62;
   localparam logic [7:0] SEG_A_STEP_LO_IDX = 8'h63;
   localparam logic [7:0] SEG_A_LENGTH_IDX  = 8'h64;
   localparam logic [7:0] SEG_B_CTRL_IDX    = 8'h65;
   localparam logic [7:0] SEG_B_STEP_HI_IDX = 8'h66;
   localparam logic [7:0] SEG_B_STEP_LO_IDX = 8'h67;
   localparam logic [7:0] SEG_B_LENGTH_IDX  = 8'h68;
   localparam logic [7:0] CAL_WAIT_IDX      = 8'h69;
   localparam logic [7:0] CAL_SHIFT_IDX     = 8'h6a;
   localparam logic [7:0] UNUSED_RB_IDX     = 8'h6b;
   localparam logic [7:0] RAMP_CTRL_IDX     = 8'h7c;
   localparam logic [7:0] RAMP_STATUS_IDX   = 8'h7d;
   localparam logic [7:0] NUM_BASE_IDX      = 8'h7e;
   localparam int         NUM_CFG_REGS      = 10;
   localparam int         ADDR_W            = 10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CFG_RESET        = 16'h0000;
   localparam logic [15:0] CAL_WAIT_RESET   = 16'h4440;
   localparam logic [15:0] CAL_SHIFT_RESET  = 16'h0007;
   localparam logic [31:0] NUM_BASE_RESET   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int TRIG_A_LSB      = 3;
   localparam int TRIG_B_LSB      = 7;
   localparam int SEG_A_CLR_BIT   = 15;
   localparam int STEP_HI_A_LSB   = 2;
   localparam int SEG_A_DBL_BIT   = 0;
   localparam int SEG_B_DBL_BIT   = 6;
   localparam int SEG_B_CLR_BIT   = 5;
   localparam int SUCCESSOR_BIT   = 4;
   localparam int MANUAL_BIT      = 5;
   localparam int CAL_WAIT_LSB    = 6;
   localparam int SEG_CAL_BIT     = 4;
   localparam int STEP_W          = 30;
   localparam int CAL_CNT_W       = 17;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] TRIG_OFF        = 4'h0;
   localparam logic [3:0] TRIG_CLK_RISE   = 4'h1;
   localparam logic [3:0] TRIG_DIR_RISE   = 4'h2;
   localparam logic [3:0] TRIG_ALWAYS     = 4'h4;
   localparam logic [3:0] TRIG_CLK_FALL   = 4'h9;
   localparam logic [3:0] TRIG_DIR_FALL   = 4'ha;
   localparam logic [1:0] ADV_TIMEOUT     = 2'h0;
   localparam logic [1:0] ADV_TRIG_A      = 2'h1;
   localparam logic [1:0] ADV_TRIG_B      = 2'h2;
   localparam logic [1:0] RESP_OKAY       = 2'b00;
   localparam logic [1:0] RESP_SLVERR     = 2'b10;

   typedef enum logic [1:0] {FRG_IDLE, FRG_CAL, FRG_RUN} frg_state_t;
endpackage : frg_pkg

/* tb/frg_ramp_core_chk.sv */
// checker: bus answer and ramp sequencing properties of the ramp core
`timescale 1ns/1ns
`default_nettype none
module frg_ramp_core_chk
   import frg_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset,
   input wire logic              clkEn,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [31:0]       fracNumerator,
   input wire logic              segBActive,
   input wire logic              rampRunning,
   input wire logic              vcoCalStart,
   input wire logic              vcoCalBusy
);
   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic rdTaken;
   assign rdTaken = clkEn && s_axi_arvalid && s_axi_arready;
   property p_rd_answer; rdTaken |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_unused; rdTaken && s_axi_araddr[9:2] == UNUSED_RB_IDX
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY; endproperty
   a_rd_unused: assert property (p_rd_unused) else $error("unused register not zero");
   property p_rd_unmapped; rdTaken && s_axi_araddr[9:2] < TRIG_CFG_IDX
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");
   property p_wr_done; clkEn && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_wr_done: assert property (p_wr_done) else $error("write response held");
   property p_cal_pulse; clkEn && vcoCalStart |=> !vcoCalStart; endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("cal start too long");
   property p_cal_busy; vcoCalStart |-> ##[0:2] vcoCalBusy; endproperty
   a_cal_busy: assert property (p_cal_busy) else $error("cal wait missing");
   property p_segb_run; segBActive |-> rampRunning; endproperty
   a_segb_run: assert property (p_segb_run) else $error("segment b while idle");
   property p_busy_run; vcoCalBusy |-> rampRunning; endproperty
   a_busy_run: assert property (p_busy_run) else $error("cal wait while idle");
   property p_freeze; !clkEn |=> $stable(fracNumerator); endproperty
   a_freeze: assert property (p_freeze) else $error("numerator moved while frozen");
   c_seg_b: cover property ($rose(segBActive));
   c_cal: cover property (vcoCalStart);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : frg_ramp_core_chk
bind frg_ramp_core frg_ramp_core_chk u_chk (.*);
`default_nettype wire

/* tb/frg_ramp_core_tb.sv */
// testbench: register, sequencing and calibration scenarios for the ramp core
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin miscompares++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module frg_ramp_core_tb
   import frg_pkg::*;
;
   logic mclk = 1'h0, reset = 1'h1, clkEn = 1'h1, sweepClockPin = 1'h0, sweepDirectionPin = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, fracNumerator, rdData;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic segBActive, rampRunning, vcoCalStart, vcoCalBusy;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, rdResp;
   int miscompares = 0, samplesChecked = 0, cyc = 0, calStarts = 0;
   // reserved bits of the low halfword kept zero on every write; the upper halfword is written as ones
   logic [15:0] msk [9] = '{16'hffff, 16'hffff, 16'h0073, 16'h3fff, 16'hffff, 16'hffff,
      16'hfff3, 16'h0017, 16'h0000};
   logic [15:0] rampCfg [9] = '{16'h0000, 16'h0003, 16'h0004, 16'h0010, 16'h3fff, 16'hfffe,
      16'h0004, 16'h0000, 16'h0000};
   frg_ramp_core u_dut (.s_axi_wstrb(4'hf), .*);
   // -----------------------------------------------------------
   // bus master and helpers
   // -----------------------------------------------------------
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (vcoCalStart === 1'h1) calStarts++;
      if (cyc == 50000) begin
         miscompares++;
         testDone();
      end
   end
   task automatic testDone();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : testDone
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      lastResp = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [7:0] i);
      @(posedge mclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      rdData = s_axi_rdata;
      rdResp = s_axi_rresp;
   endtask : rd
   task automatic waitFor(input logic sel, input logic v, output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (((sel ? vcoCalBusy : segBActive) !== v) && n < 300);
   endtask : waitFor
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic tReg();
      logic [15:0] p;
      for (int k = 0; k < 9; k++) begin
         rd(SEG_A_STEP_LO_IDX + 8'(k));
         `CHK("reset value", k == 6 ? {16'h0, CAL_WAIT_RESET} : k == 7 ? {16'h0, CAL_SHIFT_RESET}
            : 32'h0, rdData);
         p = 16'ha5c3 & msk[k];
         wr(SEG_A_STEP_LO_IDX + 8'(k), {16'hffff, p});
         `CHK("write resp", RESP_OKAY, lastResp);
         rd(SEG_A_STEP_LO_IDX + 8'(k));
         `CHK("readback", {16'h0, p}, rdData);
      end
      wr(8'h20, 32'h0);
      `CHK("bad write", RESP_SLVERR, lastResp);
      rd(8'h20);
      `CHK("bad read", {RESP_SLVERR, 32'h0}, {rdResp, rdData});
   endtask : tReg
   task automatic tRamp(input logic dbl);
      logic [31:0] n0;
      int k, lb;
      wr(NUM_BASE_IDX, 32'h100);
      // double-clock run also sets b's clear, so every period restarts from the base
      for (k = 0; k < 9; k++)
         wr(SEG_A_STEP_HI_IDX + 8'(k), {16'h0, rampCfg[k] | {9'h0, {2{dbl && k == 3}}, 5'h0}});
      wr(RAMP_CTRL_IDX, 32'h1);
      waitFor(1'h0, 1'h1, k);
      n0 = fracNumerator;
      waitFor(1'h0, 1'h0, lb);
      `CHK("seg b slope", dbl ? 32'hffff_ffff : 32'hffff_fffd, fracNumerator - n0);
      waitFor(1'h0, 1'h1, k);
      `CHK("seg b cycles", 4, lb);
      `CHK("period delta", dbl ? 32'h0 : 32'h4, fracNumerator - n0);
      @(posedge mclk);
      clkEn <= 1'h0;
      repeat (4) @(posedge mclk);
      clkEn <= 1'h1;
      wr(RAMP_CTRL_IDX, 32'h0);
      `CHK("cal starts", 0, calStarts);
   endtask : tRamp
   task automatic tTrig();
      logic [3:0] codes [5] = '{TRIG_CLK_RISE, TRIG_DIR_RISE, TRIG_CLK_FALL, TRIG_DIR_FALL, TRIG_ALWAYS};
      logic [31:0] stay [2] = '{32'h13, 32'h0};
      int k;
      wr(SEG_B_CTRL_IDX, 32'h11);
      wr(SEG_B_LENGTH_IDX, 32'h64);
      foreach (codes[c]) begin
         @(posedge mclk);
         sweepClockPin <= codes[c] == TRIG_CLK_FALL;
         sweepDirectionPin <= codes[c] == TRIG_DIR_FALL;
         wr(TRIG_CFG_IDX, {25'h0, codes[c], 3'h0});
         wr(RAMP_CTRL_IDX, 32'h1);
         repeat (12) @(negedge mclk);
         `CHK("early advance", codes[c] == TRIG_ALWAYS, segBActive);
         @(posedge mclk);
         if (codes[c][0]) sweepClockPin <= ~sweepClockPin;
         else sweepDirectionPin <= ~sweepDirectionPin;
         waitFor(1'h0, 1'h1, k);
         `CHK("trigger advance", 1'h1, k < 12);
         wr(RAMP_CTRL_IDX, 32'h0);
      end
      wr(TRIG_CFG_IDX, {25'h0, TRIG_ALWAYS, 3'h0});
      foreach (stay[s]) begin
         wr(SEG_B_CTRL_IDX, stay[s]);
         wr(RAMP_CTRL_IDX, 32'h1);
         repeat (40) @(negedge mclk);
         `CHK("stays in a", 1'h0, segBActive);
         wr(RAMP_CTRL_IDX, 32'h0);
      end
   endtask : tTrig
   task automatic tCal();
      int k;
      wr(SEG_B_CTRL_IDX, 32'h10);
      wr(CAL_SHIFT_IDX, 32'h11);
      wr(CAL_WAIT_IDX, 32'h80);
      wr(RAMP_CTRL_IDX, 32'h1);
      waitFor(1'h1, 1'h1, k);
      waitFor(1'h1, 1'h0, k);
      `CHK("cal wait", 4, k);
      waitFor(1'h1, 1'h1, k);
      `CHK("next seg cal", 1'h1, k < 20);
      wr(RAMP_CTRL_IDX, 32'h0);
      wr(CAL_WAIT_IDX, 32'ha0);
      k = calStarts;
      wr(RAMP_CTRL_IDX, 32'h1);
      repeat (40) @(posedge mclk);
      `CHK("manual cal", k, calStarts);
      wr(RAMP_CTRL_IDX, 32'h0);
   endtask : tCal
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'h0;
      tReg();
      tRamp(1'h0);
      tRamp(1'h1);
      tTrig();
      tCal();
      testDone();
   end
endmodule : frg_ramp_core_tb
`default_nettype wire
